// ### src/ep_handshake_filter.sv
`timescale 1ns/1ps
`default_nettype none
module ep_handshake_filter #(
	parameter int CLASS = 0
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic bus_reset,
	input wire logic [1:0] mode,
	input wire logic hs_valid,
	input wire logic [1:0] hs_kind,
	output logic hit
);

	typedef struct packed {
		logic ack_seen;
	} filt_state_t;

	filt_state_t st;
	filt_state_t next_st;
	logic is_ack;
	logic is_nak;
	logic is_stall;
	logic first_nak;
	logic pass;

	// ==========================================================================
	// Handshake selection
	always_comb begin
		next_st = st;
		is_ack = hs_kind == usb_irq_pkg::HS_ACK;
		is_nak = hs_kind == usb_irq_pkg::HS_NAK;
		is_stall = hs_kind == usb_irq_pkg::HS_STALL;
		first_nak = is_nak && st.ack_seen;
		pass = 1'b0;
		if (CLASS == usb_irq_pkg::EP_CLASS_OUT) begin
			case (mode)
				2'h0: pass = 1'b1;
				2'h1: pass = !is_nak;
				default: pass = !is_nak || first_nak;
			endcase
		end else if (CLASS == usb_irq_pkg::EP_CLASS_IN) begin
			case (mode)
				2'h0: pass = is_ack;
				2'h1: pass = !is_nak;
				default: pass = is_ack || first_nak;
			endcase
		end else begin
			case (mode)
				2'h0: pass = is_ack || is_stall || is_nak;
				2'h1: pass = is_ack || is_stall;
				default: pass = is_ack || is_stall || first_nak;
			endcase
		end
		hit = hs_valid && pass;
		// In filter modes 2 and 3 only the first NAK after an ACK counts, so any NAK disarms the tracker.
		if (hs_valid && is_ack) begin
			next_st.ack_seen = 1'b1;
		end else if (hs_valid && is_nak) begin
			next_st.ack_seen = 1'b0;
		end
		if (bus_reset) begin
			next_st.ack_seen = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================================
	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	property p_second_nak_dropped;
		(mode[1] && hs_valid && hs_kind == usb_irq_pkg::HS_NAK && !st.ack_seen) |-> !hit;
	endproperty
	a_second_nak_dropped: assert property (p_second_nak_dropped)
		else $error("NAK without a prior ACK raised an endpoint event");

	property p_ack_then_nak;
		(mode[1] && hs_valid && hs_kind == usb_irq_pkg::HS_NAK && st.ack_seen) |-> hit;
	endproperty
	a_ack_then_nak: assert property (p_ack_then_nak)
		else $error("first NAK after an ACK was not reported");

	property p_ctrl_no_nyet;
		(CLASS == usb_irq_pkg::EP_CLASS_CTRL && hs_valid && hs_kind == usb_irq_pkg::HS_NYET)
			|-> !hit;
	endproperty
	a_ctrl_no_nyet: assert property (p_ctrl_no_nyet)
		else $error("control endpoint reported a NYET");

endmodule
`default_nettype wire

// ### src/usb_irq_global.sv
// Contract
// - Force-register one bit raises matching global request.
// - Force register reads zero in low bits.
// - Force-register zero bits leave requests unchanged.
// - Force bits map events zero through seven.
// - Drive request lines zero and one.
// - Routing bit picks request line per event.
// - Routing bits clear on both resets.
// - Config bit zero selects request line polarity.
// - Config bit one selects edge or level.
// - OUT endpoint filter field selects handshakes.
// - IN endpoint filter field selects handshakes.
// - Control endpoint filter field selects handshakes.
// - Hardware event sets its pending bit only when enabled; forced bits set regardless.
// - Clear register ones clear, reads zero.
`timescale 1ns/1ps
`default_nettype none
module usb_irq_global (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] hw_event,
	input wire logic bus_reset,
	input wire logic [2:0] ep_hs_valid,
	input wire logic [5:0] ep_hs_kind,
	output logic irq_req0,
	output logic irq_req1,
	output logic ep_irq
);

	typedef struct packed {
		logic [7:0] enable;
		logic [7:0] pending;
		logic [7:0] route;
		logic polarity;
		logic edge_mode;
		logic [1:0] out_filter;
		logic [1:0] in_filter;
		logic [1:0] ctrl_filter;
		logic [2:0] ep_status;
		logic [2:0] ep_mask;
		logic [31:0] rdata;
		logic req0;
		logic req1;
		logic ep_irq;
	} state_t;

	localparam state_t RESET_ST = '{
		enable: usb_irq_pkg::ENABLE_RESET,
		pending: usb_irq_pkg::PENDING_RESET,
		route: usb_irq_pkg::ROUTE_RESET,
		polarity: usb_irq_pkg::POLARITY_RESET,
		edge_mode: usb_irq_pkg::EDGE_RESET,
		out_filter: usb_irq_pkg::FILTER_RESET,
		in_filter: usb_irq_pkg::FILTER_RESET,
		ctrl_filter: usb_irq_pkg::FILTER_RESET,
		ep_status: usb_irq_pkg::EP_STATUS_RESET,
		ep_mask: usb_irq_pkg::EP_MASK_RESET,
		rdata: 32'h0000_0000,
		req0: 1'b0,
		req1: 1'b0,
		ep_irq: 1'b0
	};

	state_t st;
	state_t next_st;
	usb_irq_pkg::reg_sel_t sel;
	logic wr_access;
	logic rd_access;
	logic rd_setup;
	logic [7:0] wdata8;
	logic [7:0] force_bits;
	logic [7:0] clear_bits;
	logic [7:0] set_bits;
	logic [7:0] new_bits;
	logic [7:0] pend;
	logic [2:0] ep_hit;
	logic [2:0] ep_read_clear;
	logic [5:0] ep_modes;
	logic level0;
	logic level1;
	logic fresh0;
	logic fresh1;

	// ==========================================================================
	// Address decode
	function automatic usb_irq_pkg::reg_sel_t decode(input logic [31:0] addr);
		case (addr)
			usb_irq_pkg::ADDR_OUTPUT_CONFIG: decode = usb_irq_pkg::SEL_CONFIG;
			usb_irq_pkg::ADDR_ENABLE_MASK: decode = usb_irq_pkg::SEL_ENABLE;
			usb_irq_pkg::ADDR_PENDING_FLAGS: decode = usb_irq_pkg::SEL_PENDING;
			usb_irq_pkg::ADDR_CLEAR_STROBE: decode = usb_irq_pkg::SEL_CLEAR;
			usb_irq_pkg::ADDR_FORCE_SET: decode = usb_irq_pkg::SEL_FORCE;
			usb_irq_pkg::ADDR_LINE_ROUTE: decode = usb_irq_pkg::SEL_ROUTE;
			usb_irq_pkg::ADDR_EP_EVENT_STATUS: decode = usb_irq_pkg::SEL_EP_STATUS;
			usb_irq_pkg::ADDR_EP_EVENT_MASK: decode = usb_irq_pkg::SEL_EP_MASK;
			default: decode = usb_irq_pkg::SEL_NONE;
		endcase
	endfunction

	assign sel = decode(paddr);
	assign wr_access = psel && penable && pwrite;
	assign rd_access = psel && penable && !pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign wdata8 = pwdata[7:0];
	assign pready = 1'b1;
	assign pslverr = psel && penable && (sel == usb_irq_pkg::SEL_NONE);
	assign prdata = st.rdata;
	assign irq_req0 = st.req0;
	assign irq_req1 = st.req1;
	assign ep_irq = st.ep_irq;
	assign pend = st.pending;

	// ==========================================================================
	// Endpoint handshake filters
	assign ep_modes = {st.ctrl_filter, st.in_filter, st.out_filter};

	genvar gi;
	generate
		for (gi = 0; gi < usb_irq_pkg::NUM_EP_CLASSES; gi++) begin : g_filter
			ep_handshake_filter #(
				.CLASS(gi)
			) u_filter (
				.clk_sys(clk_sys),
				.srst(srst),
				.bus_reset(bus_reset),
				.mode(ep_modes[2*gi +: 2]),
				.hs_valid(ep_hs_valid[gi]),
				.hs_kind(ep_hs_kind[2*gi +: 2]),
				.hit(ep_hit[gi])
			);
		end
	endgenerate

	// ==========================================================================
	// Event capture
	// Hardware events land only on enabled bits; forced bits land unconditionally.
	assign force_bits = (wr_access && sel == usb_irq_pkg::SEL_FORCE) ? wdata8 : 8'h00;
	assign clear_bits = (wr_access && sel == usb_irq_pkg::SEL_CLEAR) ? wdata8 : 8'h00;
	assign set_bits = (hw_event & st.enable) | force_bits;
	// A read clears only the bits it returned, so an event in between is kept.
	assign ep_read_clear = (rd_access && sel == usb_irq_pkg::SEL_EP_STATUS) ?
		st.rdata[2:0] : 3'h0;

	// ==========================================================================
	// Next state
	always_comb begin
		next_st = st;
		new_bits = 8'h00;
		level0 = 1'b0;
		level1 = 1'b0;
		fresh0 = 1'b0;
		fresh1 = 1'b0;
		if (wr_access) begin
			case (sel)
				usb_irq_pkg::SEL_CONFIG: begin
					next_st.polarity = pwdata[usb_irq_pkg::CFG_POLARITY_BIT];
					next_st.edge_mode = pwdata[usb_irq_pkg::CFG_EDGE_BIT];
					next_st.out_filter = pwdata[usb_irq_pkg::CFG_OUT_FILTER_LSB +: 2];
					next_st.in_filter = pwdata[usb_irq_pkg::CFG_IN_FILTER_LSB +: 2];
					next_st.ctrl_filter = pwdata[usb_irq_pkg::CFG_CTRL_FILTER_LSB +: 2];
				end
				usb_irq_pkg::SEL_ENABLE: begin
					next_st.enable = wdata8;
				end
				usb_irq_pkg::SEL_ROUTE: begin
					next_st.route = wdata8;
				end
				usb_irq_pkg::SEL_EP_MASK: begin
					next_st.ep_mask = pwdata[2:0];
				end
				default: begin
				end
			endcase
		end
		next_st.pending = st.pending;
		// Bus reset restores its defaults but leaves polarity and edge alone.
		if (bus_reset) begin
			next_st.route = usb_irq_pkg::ROUTE_RESET;
			next_st.enable = next_st.enable & usb_irq_pkg::BUS_RESET_KEEP;
			next_st.pending = st.pending & usb_irq_pkg::BUS_RESET_KEEP;
			next_st.out_filter = usb_irq_pkg::FILTER_RESET;
			next_st.in_filter = usb_irq_pkg::FILTER_RESET;
			next_st.ctrl_filter = usb_irq_pkg::FILTER_RESET;
		end
		// Setting wins over clearing in the same cycle.
		next_st.pending = (next_st.pending & ~clear_bits) | set_bits;
		new_bits = next_st.pending & ~st.pending;
		next_st.ep_status = (st.ep_status & ~ep_read_clear) | ep_hit;
		next_st.ep_irq = |(next_st.ep_status & next_st.ep_mask);
		// Both lines are shaped from the same pending vector, forced or not.
		level0 = |(next_st.pending & ~next_st.route);
		level1 = |(next_st.pending & next_st.route);
		fresh0 = |(new_bits & ~next_st.route);
		fresh1 = |(new_bits & next_st.route);
		if (next_st.edge_mode) begin
			next_st.req0 = fresh0 ^ next_st.polarity;
			next_st.req1 = fresh1 ^ next_st.polarity;
		end else begin
			next_st.req0 = level0 ^ next_st.polarity;
			next_st.req1 = level1 ^ next_st.polarity;
		end
		if (rd_setup) begin
			case (sel)
				usb_irq_pkg::SEL_CONFIG: next_st.rdata = {24'h00_0000, st.ctrl_filter,
					st.in_filter, st.out_filter, st.edge_mode, st.polarity};
				usb_irq_pkg::SEL_ENABLE: next_st.rdata = {24'h00_0000, st.enable};
				usb_irq_pkg::SEL_PENDING: next_st.rdata = {24'h00_0000, st.pending};
				usb_irq_pkg::SEL_ROUTE: next_st.rdata = {24'h00_0000, st.route};
				usb_irq_pkg::SEL_EP_STATUS: next_st.rdata = {29'h0000_0000, st.ep_status};
				usb_irq_pkg::SEL_EP_MASK: next_st.rdata = {29'h0000_0000, st.ep_mask};
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st <= RESET_ST;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================================
	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	property p_force_sets;
		(wr_access && sel == usb_irq_pkg::SEL_FORCE && !bus_reset)
			|=> ((pend & $past(wdata8)) == $past(wdata8));
	endproperty
	a_force_sets: assert property (p_force_sets)
		else $error("forced bit did not become pending");

	property p_force_reads_zero;
		(rd_setup && sel == usb_irq_pkg::SEL_FORCE) |=> (prdata[7:0] == 8'h00);
	endproperty
	a_force_reads_zero: assert property (p_force_reads_zero)
		else $error("force register read back nonzero");

	property p_force_zero_keeps;
		(wr_access && sel == usb_irq_pkg::SEL_FORCE && wdata8 == 8'h00
			&& !bus_reset && hw_event == 8'h00) |=> $stable(pend);
	endproperty
	a_force_zero_keeps: assert property (p_force_zero_keeps)
		else $error("zero write to force register changed pending");

	property p_force_bit_map;
		(wr_access && sel == usb_irq_pkg::SEL_FORCE && wdata8 == 8'h80
			&& !bus_reset && hw_event == 8'h00) |=> (pend == ($past(pend) | 8'h80));
	endproperty
	a_force_bit_map: assert property (p_force_bit_map)
		else $error("force bit 7 did not map to the setup event");

	property p_level_lines;
		!st.edge_mode |-> (irq_req0 == (|(pend & ~st.route) ^ st.polarity))
			&& (irq_req1 == (|(pend & st.route) ^ st.polarity));
	endproperty
	a_level_lines: assert property (p_level_lines)
		else $error("request line does not follow routed pending bits");

	property p_route_bus_reset;
		bus_reset |=> (st.route == 8'h00) && (irq_req1 == st.polarity);
	endproperty
	a_route_bus_reset: assert property (p_route_bus_reset)
		else $error("routing not cleared by bus reset");

	property p_polarity_inverts;
		(st.polarity && !st.edge_mode && pend == 8'h00) |-> (irq_req0 && irq_req1);
	endproperty
	a_polarity_inverts: assert property (p_polarity_inverts)
		else $error("active-low lines not idle high");

	property p_edge_pulse;
		(st.edge_mode && !st.polarity && irq_req0)
			##1 (st.edge_mode && !st.polarity && $stable(pend)) |-> !irq_req0;
	endproperty
	a_edge_pulse: assert property (p_edge_pulse)
		else $error("edge request stayed high without a new event");

	property p_enable_gates;
		(hw_event != 8'h00 && st.enable == 8'h00 && !wr_access)
			|=> ((pend & ~$past(pend)) == 8'h00);
	endproperty
	a_enable_gates: assert property (p_enable_gates)
		else $error("disabled event set a pending bit");

	property p_clear_works;
		(wr_access && sel == usb_irq_pkg::SEL_CLEAR && set_bits == 8'h00)
			|=> ((pend & $past(wdata8)) == 8'h00);
	endproperty
	a_clear_works: assert property (p_clear_works)
		else $error("clear write left a pending bit set");

	property p_cfg_survives;
		(bus_reset && !wr_access) |=> $stable(st.polarity) && $stable(st.edge_mode);
	endproperty
	a_cfg_survives: assert property (p_cfg_survives)
		else $error("bus reset changed polarity or edge");

	property p_forced_routed;
		(wr_access && sel == usb_irq_pkg::SEL_FORCE && wdata8 == 8'h01 && !bus_reset
			&& !st.edge_mode && !st.polarity && st.route == 8'h01) |=> irq_req1;
	endproperty
	a_forced_routed: assert property (p_forced_routed)
		else $error("forced event not routed to request 1");

	property p_clear_reads_zero;
		(rd_setup && sel == usb_irq_pkg::SEL_CLEAR) |=> (prdata[7:0] == 8'h00);
	endproperty
	a_clear_reads_zero: assert property (p_clear_reads_zero)
		else $error("clear register read back nonzero");

	property p_enabled_event_sets;
		(hw_event != 8'h00)
			|=> ((pend & $past(hw_event & st.enable)) == $past(hw_event & st.enable));
	endproperty
	a_enabled_event_sets: assert property (p_enabled_event_sets)
		else $error("enabled event did not become pending");

	property p_force_to_line0;
		(wr_access && sel == usb_irq_pkg::SEL_FORCE && wdata8 != 8'h00 && !bus_reset
			&& !st.edge_mode && !st.polarity && (wdata8 & st.route) == 8'h00) |=> irq_req0;
	endproperty
	a_force_to_line0: assert property (p_force_to_line0)
		else $error("forced event not routed to request 0");

endmodule
`default_nettype wire

// ### src/usb_irq_pkg.sv
`default_nettype none
package usb_irq_pkg;

	// ==========================================================================
	// Register byte addresses
	localparam logic [31:0] ADDR_OUTPUT_CONFIG = 32'h8004_1010;
	localparam logic [31:0] ADDR_ENABLE_MASK = 32'h8004_108c;
	localparam logic [31:0] ADDR_PENDING_FLAGS = 32'h8004_1094;
	localparam logic [31:0] ADDR_CLEAR_STROBE = 32'h8004_10ac;
	localparam logic [31:0] ADDR_FORCE_SET = 32'h8004_10b0;
	localparam logic [31:0] ADDR_LINE_ROUTE = 32'h8004_10b4;
	localparam logic [31:0] ADDR_EP_EVENT_STATUS = 32'h8004_10c0;
	localparam logic [31:0] ADDR_EP_EVENT_MASK = 32'h8004_10c4;

	typedef enum logic [3:0] {
		SEL_NONE,
		SEL_CONFIG,
		SEL_ENABLE,
		SEL_PENDING,
		SEL_CLEAR,
		SEL_FORCE,
		SEL_ROUTE,
		SEL_EP_STATUS,
		SEL_EP_MASK
	} reg_sel_t;

	// ==========================================================================
	// Field positions and widths
	localparam int NUM_EVENTS = 8;
	localparam int NUM_EP_CLASSES = 3;
	localparam int CFG_POLARITY_BIT = 0;
	localparam int CFG_EDGE_BIT = 1;
	localparam int CFG_OUT_FILTER_LSB = 2;
	localparam int CFG_IN_FILTER_LSB = 4;
	localparam int CFG_CTRL_FILTER_LSB = 6;

	// Event bits that survive a USB bus reset in the enable and pending registers.
	localparam logic [7:0] BUS_RESET_KEEP = 8'h01;

	// ==========================================================================
	// Reset values
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] PENDING_RESET = 8'h00;
	localparam logic [7:0] ROUTE_RESET = 8'h00;
	localparam logic POLARITY_RESET = 1'b0;
	localparam logic EDGE_RESET = 1'b0;
	localparam logic [1:0] FILTER_RESET = 2'h3;
	localparam logic [2:0] EP_STATUS_RESET = 3'h0;
	localparam logic [2:0] EP_MASK_RESET = 3'h0;

	// ==========================================================================
	// Endpoint classes and handshake kinds
	localparam int EP_CLASS_OUT = 0;
	localparam int EP_CLASS_IN = 1;
	localparam int EP_CLASS_CTRL = 2;

	typedef enum logic [1:0] {
		HS_ACK,
		HS_NAK,
		HS_STALL,
		HS_NYET
	} hs_kind_t;

endpackage
`default_nettype wire

// ### tb/irq_sink_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Host interrupt controller: decodes both request lines and counts new requests.
module irq_sink_model (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic irq_req0,
	input wire logic irq_req1,
	input wire logic active_low,
	output logic [1:0] active,
	output logic [7:0] cnt0,
	output logic [7:0] cnt1
);
	logic [1:0] prev;
	assign active = {irq_req1, irq_req0} ^ {2{active_low}};
	// Counting rising requests lets one model serve both level and edge signalling.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			prev <= 2'h0;
			cnt0 <= 8'h00;
			cnt1 <= 8'h00;
		end else begin
			prev <= active;
			if (active[0] && !prev[0]) cnt0 <= cnt0 + 8'h01;
			if (active[1] && !prev[1]) cnt1 <= cnt1 + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ### tb/test_usb_irq_global.sv
`timescale 1ns/1ps
`default_nettype none
module test_usb_irq_global;
	logic clk_sys = 1'b0;
	logic srst, psel, penable, pwrite, pready, pslverr, bus_reset, err;
	logic irq_req0, irq_req1, ep_irq, active_low, x;
	logic [31:0] paddr, pwdata, prdata, rd, n;
	logic [7:0] hw_event, cnt0, cnt1;
	logic [2:0] ep_hs_valid, armed;
	logic [5:0] ep_hs_kind;
	logic [1:0] active;
	usb_irq_pkg::hs_kind_t seq [5];
	int num_errors = 0;
	int checks_done = 0;
	always #20 clk_sys = ~clk_sys;
	usb_irq_global usb_irq_global_inst (.clk_sys(clk_sys), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hw_event(hw_event), .bus_reset(bus_reset),
		.ep_hs_valid(ep_hs_valid), .ep_hs_kind(ep_hs_kind), .irq_req0(irq_req0),
		.irq_req1(irq_req1), .ep_irq(ep_irq));
	irq_sink_model irq_sink_model_inst (.clk_sys(clk_sys), .srst(srst), .irq_req0(irq_req0),
		.irq_req1(irq_req1), .active_low(active_low), .active(active), .cnt0(cnt0),
		.cnt1(cnt1));
	// ============================================================================
	// Bus and stimulus tasks
	task end_of_test;
		if (num_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// Bits 31:8 have no defined read value, so only the low byte is compared.
	task rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd & 32'h0000_00ff);
	endtask
	task pulse(input logic [7:0] m, input logic br);
		@(posedge clk_sys);
		hw_event <= m;
		bus_reset <= br;
		@(posedge clk_sys);
		hw_event <= 8'h00;
		bus_reset <= 1'b0;
		#1;
	endtask
	task ep_pulse(input int c, input logic [1:0] k);
		@(posedge clk_sys);
		ep_hs_valid <= 3'h1 << c;
		ep_hs_kind <= {3{k}};
		@(posedge clk_sys);
		ep_hs_valid <= 3'h0;
		#1;
	endtask
	function automatic logic hit_of(int c, logic [1:0] m, logic [1:0] k, logic arm);
		case (k)
			usb_irq_pkg::HS_ACK: return 1'b1;
			usb_irq_pkg::HS_NAK: return (m == 2'h0 && c != usb_irq_pkg::EP_CLASS_IN)
				|| (m[1] && arm);
			usb_irq_pkg::HS_STALL: return c != usb_irq_pkg::EP_CLASS_IN || m == 2'h1;
			default: return c == usb_irq_pkg::EP_CLASS_OUT
				|| (c == usb_irq_pkg::EP_CLASS_IN && m == 2'h1);
		endcase
	endfunction
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		end_of_test();
	end
	// ============================================================================
	// Test sequence
	initial begin
		{srst, psel, penable, pwrite, bus_reset, active_low} = 6'b100000;
		{paddr, pwdata, hw_event, ep_hs_valid, ep_hs_kind} = '0;
		seq = '{usb_irq_pkg::HS_ACK, usb_irq_pkg::HS_NAK, usb_irq_pkg::HS_NAK,
			usb_irq_pkg::HS_STALL, usb_irq_pkg::HS_NYET};
		repeat (4) @(posedge clk_sys);
		srst <= 1'b0;
		rdchk("config", usb_irq_pkg::ADDR_OUTPUT_CONFIG, 32'hfc);
		rdchk("route", usb_irq_pkg::ADDR_LINE_ROUTE, 32'h0);
		apb(1'b0, 32'h8004_1000, 32'h0);
		chk("unmapped error", 32'h1, err);
		for (int i = 0; i < 8; i++) begin
			wr(usb_irq_pkg::ADDR_LINE_ROUTE, 32'h0);
			wr(usb_irq_pkg::ADDR_FORCE_SET, 32'h1 << i);
			chk("req0", 32'h1, irq_req0);
			chk("req1", 32'h0, irq_req1);
			rdchk("pending", usb_irq_pkg::ADDR_PENDING_FLAGS, 32'h1 << i);
			rdchk("force read", usb_irq_pkg::ADDR_FORCE_SET, 32'h0);
			wr(usb_irq_pkg::ADDR_CLEAR_STROBE, 32'h1 << i);
			chk("req0 cleared", 32'h0, irq_req0);
			wr(usb_irq_pkg::ADDR_LINE_ROUTE, 32'h1 << i);
			n = cnt1;
			wr(usb_irq_pkg::ADDR_FORCE_SET, 32'h1 << i);
			chk("req1 routed", 32'h3, {irq_req1, irq_req0} + 32'h1);
			wr(usb_irq_pkg::ADDR_CLEAR_STROBE, 32'h1 << i);
			chk("req1 count", n + 32'h1, cnt1);
		end
		wr(usb_irq_pkg::ADDR_LINE_ROUTE, 32'h0);
		wr(usb_irq_pkg::ADDR_FORCE_SET, 32'h1);
		wr(usb_irq_pkg::ADDR_FORCE_SET, 32'h2);
		wr(usb_irq_pkg::ADDR_FORCE_SET, 32'h0);
		rdchk("pending kept", usb_irq_pkg::ADDR_PENDING_FLAGS, 32'h3);
		wr(usb_irq_pkg::ADDR_CLEAR_STROBE, 32'h1);
		rdchk("partial clear", usb_irq_pkg::ADDR_PENDING_FLAGS, 32'h2);
		rdchk("clear read", usb_irq_pkg::ADDR_CLEAR_STROBE, 32'h0);
		wr(usb_irq_pkg::ADDR_CLEAR_STROBE, 32'h2);
		pulse(8'h10, 1'b0);
		rdchk("disabled event", usb_irq_pkg::ADDR_PENDING_FLAGS, 32'h0);
		wr(usb_irq_pkg::ADDR_ENABLE_MASK, 32'h10);
		pulse(8'h10, 1'b0);
		chk("enabled event", 32'h1, irq_req0);
		wr(usb_irq_pkg::ADDR_CLEAR_STROBE, 32'h10);
		active_low = 1'b1;
		wr(usb_irq_pkg::ADDR_OUTPUT_CONFIG, 32'hfd);
		chk("idle low-active", 32'h3, {irq_req1, irq_req0});
		wr(usb_irq_pkg::ADDR_FORCE_SET, 32'h4);
		chk("low-active request", 32'h1, active);
		wr(usb_irq_pkg::ADDR_CLEAR_STROBE, 32'h4);
		active_low = 1'b0;
		wr(usb_irq_pkg::ADDR_OUTPUT_CONFIG, 32'hfe);
		n = cnt0;
		wr(usb_irq_pkg::ADDR_FORCE_SET, 32'h8);
		chk("edge pulse", 32'h1, irq_req0);
		@(posedge clk_sys);
		#1;
		chk("edge pulse end", 32'h0, irq_req0);
		chk("edge count", n + 32'h1, cnt0);
		wr(usb_irq_pkg::ADDR_CLEAR_STROBE, 32'h8);
		wr(usb_irq_pkg::ADDR_LINE_ROUTE, 32'hff);
		wr(usb_irq_pkg::ADDR_OUTPUT_CONFIG, 32'h03);
		pulse(8'h00, 1'b1);
		rdchk("route bus reset", usb_irq_pkg::ADDR_LINE_ROUTE, 32'h0);
		rdchk("config bus reset", usb_irq_pkg::ADDR_OUTPUT_CONFIG, 32'hff);
		wr(usb_irq_pkg::ADDR_OUTPUT_CONFIG, 32'hfc);
		wr(usb_irq_pkg::ADDR_EP_EVENT_MASK, 32'h7);
		armed = 3'h0;
		for (int m = 0; m < 4; m++) begin
			wr(usb_irq_pkg::ADDR_OUTPUT_CONFIG, {24'h0, {3{m[1:0]}}, 2'h0});
			for (int c = 0; c < 3; c++) begin
				for (int j = 0; j < 5; j++) begin
					x = hit_of(c, m[1:0], seq[j], armed[c]);
					if (seq[j] == usb_irq_pkg::HS_ACK) armed[c] = 1'b1;
					if (seq[j] == usb_irq_pkg::HS_NAK) armed[c] = 1'b0;
					ep_pulse(c, seq[j]);
					chk("ep irq", {31'h0, x}, ep_irq);
					rdchk("ep status", usb_irq_pkg::ADDR_EP_EVENT_STATUS, {31'h0, x} << c);
				end
			end
		end
		end_of_test();
	end
endmodule
`default_nettype wire
